// ===== verilog/gyrft_map.vh
// Purpose: offsets, field positions, reset values and timing for the rate-threshold block
// Assumes: 8-bit registers on the device's internal register port
// Notes: definitions only
`ifndef GYRFT_MAP_VH
`define GYRFT_MAP_VH
`define GYRFT_ADDR_CTRL0 8'h0d
`define GYRFT_ADDR_CFG 8'h0e
`define GYRFT_ADDR_SRC 8'h0f
`define GYRFT_RST_CTRL0 8'h00
`define GYRFT_RST_CFG 8'h00
`define GYRFT_RST_SRC 8'h00
`define GYRFT_CTRL0_LPBW_HI 7
`define GYRFT_CTRL0_LPBW_LO 6
`define GYRFT_CTRL0_WIRE 5
`define GYRFT_CTRL0_SEL_HI 4
`define GYRFT_CTRL0_SEL_LO 3
`define GYRFT_CTRL0_HPEN 2
`define GYRFT_CTRL0_RANGE_HI 1
`define GYRFT_CTRL0_RANGE_LO 0
`define GYRFT_CFG_LATCH 3
`define GYRFT_CFG_ZEN 2
`define GYRFT_CFG_YEN 1
`define GYRFT_CFG_XEN 0
`define GYRFT_CFG_MASK 8'h0f
`define GYRFT_SRC_ANY 6
`define GYRFT_MODE_STANDBY 2'h0
`define GYRFT_MODE_READY 2'h1
`define GYRFT_MODE_ACTIVE 2'h2
`define GYRFT_RANGE_MAX_DPS 4000
`define GYRFT_HP_INIT_NS 50
`define GYRFT_CLK_NS 50
`endif

// ===== verilog/gyrft_axis.v
// Purpose: one axis of the rate-threshold detector with debounce, sign and latch
// Assumes: sample_i marks one new filtered sample, rate two's complement
// Notes: flags clear on read only when latching is on
`timescale 1ns/1ns
`default_nettype none
module gyrft_axis #(
  parameter W = 16,
  parameter CW = 8
) (
  input wire clk_i,
  input wire reset_i,
  input wire clear_i,
  input wire enable_i,
  input wire latch_i,
  input wire read_clr_i,
  input wire sample_i,
  input wire [W-1:0] rate_i,
  input wire [W-1:0] threshold_i,
  input wire [CW-1:0] debounce_i,
  output reg hit_o,
  output reg sign_o
);
  reg [CW-1:0] count;
  reg live_hit;
  wire neg = rate_i[W-1];
  wire [W-1:0] mag = neg ? (~rate_i + {{(W-1){1'b0}}, 1'b1}) : rate_i;
  wire above = mag > threshold_i;
  wire want_change = above != live_hit;
  wire settle = want_change && (count >= debounce_i);
  wire next_live = settle ? above : live_hit;
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (reset_i || clear_i || !enable_i)
    begin
      count <= {CW{1'b0}};
      live_hit <= 1'b0;
      hit_o <= 1'b0;
      sign_o <= 1'b0;
    end
    else
    begin
      if (sample_i)
      begin
        // debounce: count samples on the other side of threshold
        if (!want_change || settle)
          count <= {CW{1'b0}};
        else
          count <= count + {{(CW-1){1'b0}}, 1'b1};
        live_hit <= next_live;
      end
      if (latch_i)
      begin
        // latched: sample set wins over the read clear
        if (sample_i && next_live)
          hit_o <= 1'b1;
        else if (read_clr_i)
          hit_o <= 1'b0;
        if (sample_i && next_live)
          sign_o <= neg;
        else if (read_clr_i)
          sign_o <= 1'b0;
        else if (sample_i && !hit_o)
          sign_o <= neg;
      end
      else
      begin
        if (sample_i)
        begin
          hit_o <= next_live;
          sign_o <= neg;
        end
      end
    end
  end
endmodule // gyrft_axis
`default_nettype wire

// ===== verilog/gyrft_edge.v
// Purpose: detects entry into Active mode and sample-rate changes
// Assumes: mode and rate codes held steady between changes
// Notes: pulses one cycle
`timescale 1ns/1ns
`default_nettype none
`include "gyrft_map.vh"
module gyrft_edge #(
  parameter RW = 3
) (
  input wire clk_i,
  input wire reset_i,
  input wire [1:0] mode_i,
  input wire [RW-1:0] rate_sel_i,
  output wire to_active_o,
  output wire mode_change_o,
  output wire rate_change_o
);
  reg [1:0] last_mode;
  reg [RW-1:0] last_rate;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      last_mode <= `GYRFT_MODE_STANDBY;
      last_rate <= {RW{1'b0}};
    end
    else
    begin
      last_mode <= mode_i;
      last_rate <= rate_sel_i;
    end
  end
  assign to_active_o = (mode_i == `GYRFT_MODE_ACTIVE) &&
    ((last_mode == `GYRFT_MODE_STANDBY) || (last_mode == `GYRFT_MODE_READY));
  assign mode_change_o = mode_i != last_mode;
  assign rate_change_o = rate_sel_i != last_rate;
endmodule // gyrft_edge
`default_nettype wire

// ===== verilog/gyrft_top.v
// Purpose: general control, rate-threshold config and source registers
// Assumes: register port strobes one cycle per access, 8-bit data
// Notes: filter arithmetic outside; this block drives its controls
// Functional notes
// - bits 7:6 pick low-pass cutoff
// - bit 5 selects three-wire serial
// - bits 4:3 pick high-pass cutoff
// - bit 2 enables high-pass filtered path
// - high-pass reinit on mode, rate, zero-rate
// - bits 1:0 select full-scale range
// - range doubler doubles range, max 4000
// - config at 0x0e, detector reset entering Active
// - config bit 3 latches event flags
// - config bits 2:0 enable Z, Y, X
// - source at 0x0f, cleared entering Active
// - source layout: 0, any, Z, sign...
// - any flag ORs axes, read-clears if latched
// - axis flag debounced above and below threshold
// - sign bit 1 negative, read-clears if latched
`timescale 1ns/1ns
`default_nettype none
`include "gyrft_map.vh"
module gyrft_top #(
  parameter W = 16,
  parameter CW = 8,
  parameter RW = 3
) (
  input wire SYS_CLK_I,
  input wire RESET_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire [1:0] MODE_I,
  input wire [RW-1:0] SAMPLE_RATE_I,
  input wire ZERO_RATE_I,
  input wire RANGE_DOUBLER_I,
  input wire SAMPLE_I,
  input wire [W-1:0] X_RATE_I,
  input wire [W-1:0] Y_RATE_I,
  input wire [W-1:0] Z_RATE_I,
  input wire [W-1:0] THRESHOLD_LEVEL_I,
  input wire [CW-1:0] DEBOUNCE_SAMPLES_I,
  output reg [7:0] REG_RDATA_O,
  output reg [1:0] LOWPASS_BANDWIDTH_SEL_O,
  output reg SERIAL_WIRE_COUNT_SEL_O,
  output reg [1:0] HIGHPASS_CUTOFF_SEL_O,
  output reg HIGHPASS_ENABLE_O,
  output reg [1:0] RANGE_CHOICE_O,
  output reg [12:0] RANGE_DPS_O,
  output reg HIGHPASS_INIT_O,
  output reg ANY_AXIS_EVENT_O
);
  reg [7:0] general_control_zero;
  reg [7:0] rate_threshold_config;
  reg [12:0] next_range;
  wire to_active;
  wire mode_change;
  wire rate_change;
  wire x_hit;
  wire y_hit;
  wire z_hit;
  wire x_sign;
  wire y_sign;
  wire z_sign;
  wire latch_on = rate_threshold_config[`GYRFT_CFG_LATCH];
  wire src_read = REG_RD_I && (REG_ADDR_I == `GYRFT_ADDR_SRC);
  wire read_clr = src_read && latch_on;
  wire any_axis_event = x_hit | y_hit | z_hit;
  wire [7:0] rate_threshold_source = {1'b0, any_axis_event, z_hit, z_sign,
    y_hit, y_sign, x_hit, x_sign};
  ////////////////////////////////////////////////////////////
  gyrft_edge #(.RW(RW)) u_edge (
    .clk_i(SYS_CLK_I),
    .reset_i(RESET_I),
    .mode_i(MODE_I),
    .rate_sel_i(SAMPLE_RATE_I),
    .to_active_o(to_active),
    .mode_change_o(mode_change),
    .rate_change_o(rate_change)
  );
  ////////////////////////////////////////////////////////////
  gyrft_axis #(.W(W), .CW(CW)) u_x (
    .clk_i(SYS_CLK_I),
    .reset_i(RESET_I),
    .clear_i(to_active),
    .enable_i(rate_threshold_config[`GYRFT_CFG_XEN]),
    .latch_i(latch_on),
    .read_clr_i(read_clr),
    .sample_i(SAMPLE_I),
    .rate_i(X_RATE_I),
    .threshold_i(THRESHOLD_LEVEL_I),
    .debounce_i(DEBOUNCE_SAMPLES_I),
    .hit_o(x_hit),
    .sign_o(x_sign)
  );
  gyrft_axis #(.W(W), .CW(CW)) u_y (
    .clk_i(SYS_CLK_I),
    .reset_i(RESET_I),
    .clear_i(to_active),
    .enable_i(rate_threshold_config[`GYRFT_CFG_YEN]),
    .latch_i(latch_on),
    .read_clr_i(read_clr),
    .sample_i(SAMPLE_I),
    .rate_i(Y_RATE_I),
    .threshold_i(THRESHOLD_LEVEL_I),
    .debounce_i(DEBOUNCE_SAMPLES_I),
    .hit_o(y_hit),
    .sign_o(y_sign)
  );
  gyrft_axis #(.W(W), .CW(CW)) u_z (
    .clk_i(SYS_CLK_I),
    .reset_i(RESET_I),
    .clear_i(to_active),
    .enable_i(rate_threshold_config[`GYRFT_CFG_ZEN]),
    .latch_i(latch_on),
    .read_clr_i(read_clr),
    .sample_i(SAMPLE_I),
    .rate_i(Z_RATE_I),
    .threshold_i(THRESHOLD_LEVEL_I),
    .debounce_i(DEBOUNCE_SAMPLES_I),
    .hit_o(z_hit),
    .sign_o(z_sign)
  );
  ////////////////////////////////////////////////////////////
  // register writes; host keeps to idle-mode timing
  always @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      general_control_zero <= `GYRFT_RST_CTRL0;
      rate_threshold_config <= `GYRFT_RST_CFG;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == `GYRFT_ADDR_CTRL0)
        general_control_zero <= REG_WDATA_I;
      else if (REG_ADDR_I == `GYRFT_ADDR_CFG)
        rate_threshold_config <= REG_WDATA_I & `GYRFT_CFG_MASK;
    end
  end
  ////////////////////////////////////////////////////////////
  // range in dps after doubling
  always @*
  begin
    case (general_control_zero[`GYRFT_CTRL0_RANGE_HI:`GYRFT_CTRL0_RANGE_LO])
      2'h0: next_range = 13'd2000;
      2'h1: next_range = 13'd1000;
      2'h2: next_range = 13'd500;
      default: next_range = 13'd250;
    endcase
    if (RANGE_DOUBLER_I)
      next_range = next_range << 1;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      REG_RDATA_O <= 8'h00;
      LOWPASS_BANDWIDTH_SEL_O <= 2'h0;
      SERIAL_WIRE_COUNT_SEL_O <= 1'b0;
      HIGHPASS_CUTOFF_SEL_O <= 2'h0;
      HIGHPASS_ENABLE_O <= 1'b0;
      RANGE_CHOICE_O <= 2'h0;
      RANGE_DPS_O <= 13'd2000;
      HIGHPASS_INIT_O <= 1'b1;
      ANY_AXIS_EVENT_O <= 1'b0;
    end
    else
    begin
      if (REG_RD_I)
      begin
        if (REG_ADDR_I == `GYRFT_ADDR_CTRL0)
          REG_RDATA_O <= general_control_zero;
        else if (REG_ADDR_I == `GYRFT_ADDR_CFG)
          REG_RDATA_O <= rate_threshold_config;
        else if (REG_ADDR_I == `GYRFT_ADDR_SRC)
          REG_RDATA_O <= rate_threshold_source;
        else
          REG_RDATA_O <= 8'h00;
      end
      LOWPASS_BANDWIDTH_SEL_O <=
        general_control_zero[`GYRFT_CTRL0_LPBW_HI:`GYRFT_CTRL0_LPBW_LO];
      SERIAL_WIRE_COUNT_SEL_O <= general_control_zero[`GYRFT_CTRL0_WIRE];
      HIGHPASS_CUTOFF_SEL_O <=
        general_control_zero[`GYRFT_CTRL0_SEL_HI:`GYRFT_CTRL0_SEL_LO];
      HIGHPASS_ENABLE_O <= general_control_zero[`GYRFT_CTRL0_HPEN];
      RANGE_CHOICE_O <= general_control_zero[`GYRFT_CTRL0_RANGE_HI:`GYRFT_CTRL0_RANGE_LO];
      RANGE_DPS_O <= next_range;
      HIGHPASS_INIT_O <= mode_change | rate_change | ZERO_RATE_I;
      ANY_AXIS_EVENT_O <= any_axis_event;
    end
  end
endmodule // gyrft_top
`default_nettype wire

// ===== verif/gyrft_props.sv
// Purpose: port checks of the rate-threshold register block
// Assumes: control writes at least three cycles apart
// Notes: bound to gyrft_top
`timescale 1ns/1ns
`default_nettype none
`include "gyrft_map.vh"
module gyrft_props (
  input wire SYS_CLK_I,
  input wire RESET_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [7:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire [1:0] MODE_I,
  input wire [2:0] SAMPLE_RATE_I,
  input wire ZERO_RATE_I,
  input wire RANGE_DOUBLER_I,
  input wire [7:0] REG_RDATA_O,
  input wire [1:0] LOWPASS_BANDWIDTH_SEL_O,
  input wire SERIAL_WIRE_COUNT_SEL_O,
  input wire [1:0] HIGHPASS_CUTOFF_SEL_O,
  input wire HIGHPASS_ENABLE_O,
  input wire [1:0] RANGE_CHOICE_O,
  input wire [12:0] RANGE_DPS_O,
  input wire HIGHPASS_INIT_O,
  input wire ANY_AXIS_EVENT_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_to_active;
    $past(MODE_I) != `GYRFT_MODE_ACTIVE ##0 MODE_I == `GYRFT_MODE_ACTIVE;
  endsequence
  sequence s_src_rd;
    REG_RD_I && REG_ADDR_I == 8'h0f;
  endsequence
  property p_ctrl;
    logic [7:0] v;
    (REG_WR_I && REG_ADDR_I == 8'h0d, v = REG_WDATA_I) |-> ##2 v == {LOWPASS_BANDWIDTH_SEL_O,
      SERIAL_WIRE_COUNT_SEL_O, HIGHPASS_CUTOFF_SEL_O, HIGHPASS_ENABLE_O, RANGE_CHOICE_O};
  endproperty
  property p_dps;
    RANGE_CHOICE_O == $past(RANGE_CHOICE_O) && RANGE_CHOICE_O == $past(RANGE_CHOICE_O, 2) &&
      RANGE_DOUBLER_I == $past(RANGE_DOUBLER_I) && RANGE_DOUBLER_I == $past(RANGE_DOUBLER_I, 2)
      |-> RANGE_DPS_O == ((13'h07d0 >> RANGE_CHOICE_O) << RANGE_DOUBLER_I);
  endproperty
  property p_init;
    MODE_I != $past(MODE_I) || SAMPLE_RATE_I != $past(SAMPLE_RATE_I) || ZERO_RATE_I
      |-> ##[1:2] HIGHPASS_INIT_O;
  endproperty
  property p_clr;
    s_to_active |-> ##[1:3] !ANY_AXIS_EVENT_O;
  endproperty
  property p_unmap;
    REG_RD_I && (REG_ADDR_I < 8'h0d || REG_ADDR_I > 8'h0f) |=> REG_RDATA_O == 8'h00;
  endproperty
  property p_cfg;
    REG_RD_I && REG_ADDR_I == 8'h0e |=> REG_RDATA_O[7:4] == 4'h0;
  endproperty
  property p_src;
    s_src_rd |=> !REG_RDATA_O[7] &&
      REG_RDATA_O[6] == (REG_RDATA_O[5] | REG_RDATA_O[3] | REG_RDATA_O[1]);
  endproperty
  property p_hold;
    !REG_RD_I |=> REG_RDATA_O == $past(REG_RDATA_O);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control fields differ from write");
  a_dps: assert property (p_dps) else $error("range in dps wrong");
  a_init: assert property (p_init) else $error("highpass init missing");
  a_clr: assert property (p_clr) else $error("event not cleared entering active");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_cfg: assert property (p_cfg) else $error("config upper bits set");
  a_src: assert property (p_src) else $error("source layout wrong");
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule // gyrft_props
bind gyrft_top gyrft_props u_props (.SYS_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
  .REG_WDATA_I, .MODE_I, .SAMPLE_RATE_I, .ZERO_RATE_I, .RANGE_DOUBLER_I, .REG_RDATA_O,
  .LOWPASS_BANDWIDTH_SEL_O, .SERIAL_WIRE_COUNT_SEL_O, .HIGHPASS_CUTOFF_SEL_O,
  .HIGHPASS_ENABLE_O, .RANGE_CHOICE_O, .RANGE_DPS_O, .HIGHPASS_INIT_O, .ANY_AXIS_EVENT_O);
`default_nettype wire

// ===== verif/gyrft_top_tb.sv
// Purpose: self-checking bench for the rate-threshold register block
// Assumes: 20 MHz clock, synchronous reset
// Notes: control rows in a table, detector cases by hand
`timescale 1ns/1ns
`default_nettype none
`include "gyrft_map.vh"
`define CHK(n, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("Error %s expected %h seen %h", n, e, g); end end
module gyrft_top_tb;
  reg SYS_CLK_I = 1'h0, RESET_I = 1'h1, REG_WR_I = 1'h0, REG_RD_I = 1'h0, SAMPLE_I = 1'h0;
  reg ZERO_RATE_I = 1'h0, RANGE_DOUBLER_I = 1'h0;
  reg [7:0] REG_ADDR_I = 8'h00, REG_WDATA_I = 8'h00, DEBOUNCE_SAMPLES_I = 8'h00, d;
  reg [1:0] MODE_I = 2'h0;
  reg [2:0] SAMPLE_RATE_I = 3'h0;
  reg [15:0] X_RATE_I = 16'h0, Y_RATE_I = 16'h0, Z_RATE_I = 16'h0, THRESHOLD_LEVEL_I = 16'h64;
  wire [7:0] REG_RDATA_O;
  wire [1:0] LOWPASS_BANDWIDTH_SEL_O, HIGHPASS_CUTOFF_SEL_O, RANGE_CHOICE_O;
  wire SERIAL_WIRE_COUNT_SEL_O, HIGHPASS_ENABLE_O, HIGHPASS_INIT_O, ANY_AXIS_EVENT_O;
  wire [12:0] RANGE_DPS_O;
  wire [7:0] fields = {LOWPASS_BANDWIDTH_SEL_O, SERIAL_WIRE_COUNT_SEL_O, HIGHPASS_CUTOFF_SEL_O,
    HIGHPASS_ENABLE_O, RANGE_CHOICE_O};
  integer miscompares = 0, tests_run = 0, i;
  reg [20:0] rows [0:4];
  gyrft_top uut (.SYS_CLK_I, .RESET_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I,
    .MODE_I, .SAMPLE_RATE_I, .ZERO_RATE_I, .RANGE_DOUBLER_I, .SAMPLE_I, .X_RATE_I, .Y_RATE_I,
    .Z_RATE_I, .THRESHOLD_LEVEL_I, .DEBOUNCE_SAMPLES_I, .REG_RDATA_O, .LOWPASS_BANDWIDTH_SEL_O,
    .SERIAL_WIRE_COUNT_SEL_O, .HIGHPASS_CUTOFF_SEL_O, .HIGHPASS_ENABLE_O, .RANGE_CHOICE_O,
    .RANGE_DPS_O, .HIGHPASS_INIT_O, .ANY_AXIS_EVENT_O);
  initial
    forever #25 SYS_CLK_I = !SYS_CLK_I;
  ////////////////////////////////////////////////////////////////////////////
  task acc(input w, input [7:0] a, input [7:0] v);
  begin
    @(posedge SYS_CLK_I);
    REG_WR_I <= w;
    REG_RD_I <= !w;
    REG_ADDR_I <= a;
    REG_WDATA_I <= v;
    @(posedge SYS_CLK_I);
    REG_WR_I <= 1'h0;
    REG_RD_I <= 1'h0;
    repeat (2) @(posedge SYS_CLK_I);
    #1 d = REG_RDATA_O;
  end
  endtask
  task smp(input [15:0] x, input [15:0] y, input [15:0] z);
  begin
    @(posedge SYS_CLK_I);
    SAMPLE_I <= 1'h1;
    X_RATE_I <= x;
    Y_RATE_I <= y;
    Z_RATE_I <= z;
    @(posedge SYS_CLK_I);
    SAMPLE_I <= 1'h0;
    repeat (2) @(posedge SYS_CLK_I);
  end
  endtask
  task mset(input [1:0] m);
  begin
    @(posedge SYS_CLK_I);
    MODE_I <= m;
    repeat (3) @(posedge SYS_CLK_I);
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // control byte, doubler, range in dps
    rows[0] = {8'h00, 1'h1, 12'hfa0};
    rows[1] = {8'h24, 1'h0, 12'h7d0};
    rows[2] = {8'hd9, 1'h1, 12'h7d0};
    rows[3] = {8'h5a, 1'h0, 12'h1f4};
    rows[4] = {8'hbf, 1'h1, 12'h1f4};
    repeat (2) @(posedge SYS_CLK_I);
    RESET_I <= 1'h0;
    #1 `CHK("rst_dps", 13'h07d0, RANGE_DPS_O)
    acc(1'h0, 8'h0d, 8'h00);
    `CHK("rst_ctrl0", 8'h00, d)
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge SYS_CLK_I);
      RANGE_DOUBLER_I <= rows[i][12];
      SAMPLE_RATE_I <= i[2:0];
      acc(1'h1, 8'h0d, rows[i][20:13]);
      acc(1'h0, 8'h0d, 8'h00);
      `CHK("ctrl0", rows[i][20:13], d)
      `CHK("fields", rows[i][20:13], fields)
      `CHK("dps", {1'h0, rows[i][11:0]}, RANGE_DPS_O)
    end
    acc(1'h1, 8'h0e, 8'hff);
    acc(1'h0, 8'h0e, 8'h00);
    `CHK("cfg", 8'h0f, d)
    acc(1'h0, 8'h20, 8'h00);
    `CHK("unmapped", 8'h00, d)
    acc(1'h1, 8'h0f, 8'hff);
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("src_ro", 8'h00, d)
    acc(1'h1, 8'h0e, 8'h01);
    mset(`GYRFT_MODE_ACTIVE);
    // x at -200, disabled axes above threshold
    smp(16'hff38, 16'h012c, 16'h012c);
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("x_neg", 8'h43, d)
    `CHK("any", 1'h1, ANY_AXIS_EVENT_O)
    smp(16'h0032, 16'h0000, 16'h0000);
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("x_low", 8'h00, d)
    mset(`GYRFT_MODE_STANDBY);
    acc(1'h1, 8'h0e, 8'h0e);
    mset(`GYRFT_MODE_ACTIVE);
    // y at 150, z at -150, x disabled
    smp(16'h01f4, 16'h0096, 16'hff6a);
    smp(16'h0000, 16'h0000, 16'h0000);
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("latched", 8'h78, d)
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("read_clr", 8'h00, d)
    smp(16'h0000, 16'h0096, 16'h0000);
    mset(`GYRFT_MODE_READY);
    mset(`GYRFT_MODE_ACTIVE);
    acc(1'h0, 8'h0f, 8'h00);
    `CHK("to_active", 8'h00, d)
    mset(`GYRFT_MODE_STANDBY);
    acc(1'h1, 8'h0e, 8'h01);
    // x above threshold, debounce of two samples
    @(posedge SYS_CLK_I);
    DEBOUNCE_SAMPLES_I <= 8'h02;
    mset(`GYRFT_MODE_ACTIVE);
    smp(16'h00c8, 16'h0000, 16'h0000);
    smp(16'h00c8, 16'h0000, 16'h0000);
    #1 `CHK("debounce_wait", 1'h0, ANY_AXIS_EVENT_O)
    smp(16'h00c8, 16'h0000, 16'h0000);
    #1 `CHK("debounce_set", 1'h1, ANY_AXIS_EVENT_O)
    @(posedge SYS_CLK_I);
    ZERO_RATE_I <= 1'h1;
    repeat (3) @(posedge SYS_CLK_I);
    #1 `CHK("hp_init", 1'h1, HIGHPASS_INIT_O)
    results;
  end
endmodule // gyrft_top_tb
`default_nettype wire
